// file: rtl/tks_fifo.sv
// Touch event store: circular buffer of fixed depth.
// Assumes the core never pushes when full nor pops when empty.
`timescale 1ns/1ps
`default_nettype none
module tks_fifo
  import tks_pkg::*;
#(
  parameter int W     = 4,
  parameter int DEPTH = TKS_FIFO_DEPTH,
  parameter int CNT_W = 5
) (
  input  wire logic  clk,
  input  wire logic  rst,
  tks_fifo_if.store  fif
);
  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] rd;
    logic [PTR_W-1:0] wr;
    logic [CNT_W-1:0] count;
  } tks_fifo_state_t;

  tks_fifo_state_t  s;
  tks_fifo_state_t  next_s;
  logic [W-1:0]     mem [DEPTH];

  // Pointer wrap at the depth, which need not be a power of two
  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  // Pointer and occupancy update
  always_comb begin
    next_s = s;
    if (fif.push) begin
      next_s.wr = bump(s.wr);
    end
    if (fif.pop) begin
      next_s.rd = bump(s.rd);
    end
    if (fif.push && !fif.pop) begin
      next_s.count = s.count + CNT_W'(1);
    end else if (fif.pop && !fif.push) begin
      next_s.count = s.count - CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Storage has no reset; occupancy guards every read
  always_ff @(posedge clk) begin
    if (fif.push) begin
      mem[s.wr] <= fif.push_data;
    end
  end

  assign fif.head  = mem[s.rd];
  assign fif.empty = (s.count == '0);
  assign fif.full  = (s.count == CNT_W'(DEPTH));
  assign fif.count = s.count;
endmodule
`default_nettype wire

// file: rtl/tks_fifo_if.sv
// Link between the sensor core and its touch event store.
// Assumes both ends share one clock; the core pushes and pops.
`timescale 1ns/1ps
`default_nettype none
interface tks_fifo_if #(
  parameter int W     = 4,
  parameter int CNT_W = 5
);
  logic             push;
  logic [W-1:0]     push_data;
  logic             pop;
  logic [W-1:0]     head;
  logic             empty;
  logic             full;
  logic [CNT_W-1:0] count;

  modport core  (output push, output push_data, output pop,
                 input head, input empty, input full, input count);
  modport store (input push, input push_data, input pop,
                 output head, output empty, output full, output count);
endinterface
`default_nettype wire

// file: rtl/tks_pkg.sv
// Constants shared by the touch keypad sensor core and its event store.
// Assumes one 250 MHz clock and an active-high asynchronous reset.
package tks_pkg;
  localparam int          TKS_FIFO_DEPTH = 30;  // Touch events held at most
  localparam int          TKS_ELECTRODES = 8;   // Electrodes scanned
  localparam int          TKS_CLK_MHZ    = 250; // System clock rate
  localparam logic        TKS_IRQ_RESET  = 1'h0;
  localparam logic        TKS_PRESSED    = 1'h1; // Event flag for a press
  localparam logic        TKS_RELEASED   = 1'h0; // Event flag for a release

  // Scan engine states, one-hot
  typedef enum logic [2:0] {
    TKS_STOP = 3'h1,  // Stop mode, configuration says halt
    TKS_RUN  = 3'h2,  // Electrodes scanned round robin
    TKS_HALT = 3'h4   // Fault pending, scanning frozen
  } tks_scan_t;
endpackage

// file: rtl/tks_sensor.sv
// Capacitive touch keypad sensor core: scan, event store, fault, interrupt.
// Assumes electrode and short-detect pins are asynchronous; host-side
// controls come from logic on clk.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Interrupt output raised when touch events wait.
// - Touch events buffered, at most thirty entries.
// - Fault flags report supply or ground shorts.
// - Fault halts scanning until cleared.
module tks_sensor
  import tks_pkg::*;
#(
  parameter int N     = TKS_ELECTRODES,
  parameter int DEPTH = TKS_FIFO_DEPTH
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [N-1:0]         touch_pin,
  input  wire logic [N-1:0]         short_vdd_pin,
  input  wire logic [N-1:0]         short_vss_pin,
  input  wire logic                 cfg_irq_enable,
  input  wire logic                 cfg_run,
  input  wire logic                 fault_clear,
  input  wire logic                 event_read,
  output logic                      touch_irq,
  output logic [$clog2(N):0]        event_data,
  output logic                      event_valid,
  output logic                      event_empty,
  output logic [$clog2(DEPTH+1)-1:0] event_count,
  output logic [N-1:0]              fault_vdd,
  output logic [N-1:0]              fault_vss,
  output logic                      fault_any,
  output logic                      scanning
);
  localparam int IDX_W = $clog2(N);
  localparam int EVW   = IDX_W + 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [N-1:0]     touch_s1;
    logic [N-1:0]     touch_s2;
    logic [N-1:0]     vdd_s1;
    logic [N-1:0]     vdd_s2;
    logic [N-1:0]     vss_s1;
    logic [N-1:0]     vss_s2;
    logic [N-1:0]     key;       // Last reported level per electrode
    logic [IDX_W-1:0] idx;       // Electrode under scan
    tks_scan_t        scan;
    logic [N-1:0]     flt_vdd;
    logic [N-1:0]     flt_vss;
    logic             irq;
    logic [EVW-1:0]   rd_data;
    logic             rd_valid;
    logic             empty;     // Store empty, registered copy
    logic             flt_any;   // Summary of both flag vectors
  } tks_state_t;

  tks_state_t s;
  tks_state_t next_s;

  tks_fifo_if #(.W(EVW), .CNT_W(CNT_W)) fif ();

  tks_fifo #(
    .W     (EVW),
    .DEPTH (DEPTH),
    .CNT_W (CNT_W)
  ) u_store (
    .clk (clk),
    .rst (rst),
    .fif (fif)
  );

  // Round-robin electrode step
  function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] i);
    next_idx = (i == IDX_W'(N - 1)) ? '0 : i + IDX_W'(1);
  endfunction

  // Any set flag in either short vector; scan gate and summary share it
  function automatic logic any_fault(
    input logic [N-1:0] v,
    input logic [N-1:0] g
  );
    any_fault = (|v) | (|g);
  endfunction

  // Occupancy the store will hold after this edge
  function automatic logic [CNT_W-1:0] count_after(
    input logic [CNT_W-1:0] c,
    input logic             up,
    input logic             down
  );
    count_after = c + CNT_W'(up) - CNT_W'(down);
  endfunction

  logic fault_now;
  logic do_pop;
  logic do_push;

  // Fault summary from sticky flags
  assign fault_now = any_fault(s.flt_vdd, s.flt_vss);
  assign do_pop    = event_read && !fif.empty;
  assign do_push   = (s.scan == TKS_RUN) && (s.key[s.idx] != s.touch_s2[s.idx])
                     && !fif.full;

  // Scan, fault and read logic
  always_comb begin
    next_s = s;
    // Second stage is the only reader of the first
    next_s.touch_s1 = touch_pin;
    next_s.touch_s2 = s.touch_s1;
    next_s.vdd_s1   = short_vdd_pin;
    next_s.vdd_s2   = s.vdd_s1;
    next_s.vss_s1   = short_vss_pin;
    next_s.vss_s2   = s.vss_s1;

    // Sticky shorts; a short seen during clear still sets
    next_s.flt_vdd = (s.flt_vdd & ~{N{fault_clear}}) | s.vdd_s2;
    next_s.flt_vss = (s.flt_vss & ~{N{fault_clear}}) | s.vss_s2;

    // Scan engine; fault freezes it regardless of run mode
    case (s.scan)
      TKS_STOP: begin
        if (fault_now) begin
          next_s.scan = TKS_HALT;
        end else if (cfg_run) begin
          next_s.scan = TKS_RUN;
        end
      end
      TKS_RUN: begin
        if (fault_now) begin
          next_s.scan = TKS_HALT;
        end else if (!cfg_run) begin
          next_s.scan = TKS_STOP;
        end else if (!(s.key[s.idx] != s.touch_s2[s.idx]) || do_push) begin
          // Change held back when full is retried on this electrode
          next_s.idx = next_idx(s.idx);
        end
      end
      TKS_HALT: begin
        // Leave only once every flag is cleared
        if (!fault_now) begin
          next_s.scan = cfg_run ? TKS_RUN : TKS_STOP;
        end
      end
      default: begin
        next_s.scan = TKS_STOP;
      end
    endcase

    // Record a level change as a press or release event
    if (do_push) begin
      next_s.key[s.idx] = s.touch_s2[s.idx];
    end

    // Read side: one-cycle valid with the popped entry
    next_s.rd_valid = do_pop;
    if (do_pop) begin
      next_s.rd_data = fif.head;
    end

    // Interrupt stands while events wait; lags the store by one edge
    // both on rise and fall, so a host sees a stable, glitch-free level
    next_s.irq = cfg_irq_enable && !fif.empty;

    // Status flags are registered so every output leaves a flop.
    // The empty flag moves on the same edge as the store count, and
    // the fault summary on the same edge as the flag vectors, so a
    // host that reads them together never sees them disagree.
    next_s.empty   = (count_after(fif.count, do_push, do_pop) == '0);
    next_s.flt_any = any_fault(next_s.flt_vdd, next_s.flt_vss);
  end

  // Reset leaves the store empty and the scan engine stopped; the
  // empty flag must come out of reset high to match a zero count,
  // otherwise a host would try to pop a store that holds nothing.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s      <= '0;
      s.scan <= TKS_STOP;
      s.irq  <= TKS_IRQ_RESET;
      s.empty <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Store traffic; the event word carries the new level as press or
  // release flag above the electrode index
  assign fif.push      = do_push;
  assign fif.push_data = {s.touch_s2[s.idx] ? TKS_PRESSED : TKS_RELEASED, s.idx};
  assign fif.pop       = do_pop;

  // Outputs straight from state
  assign touch_irq   = s.irq;
  assign event_data  = s.rd_data;
  assign event_valid = s.rd_valid;
  assign event_empty = s.empty;
  assign event_count = fif.count;
  assign fault_vdd   = s.flt_vdd;
  assign fault_vss   = s.flt_vss;
  assign fault_any   = s.flt_any;
  // Run state bit of the one-hot scan code
  assign scanning    = s.scan[1];
endmodule
`default_nettype wire

// file: tb/tks_assertions.sv
// Port checker for the touch sensor core.
// Assumes one clock and the active-high reset of the core.
`timescale 1ns/1ps
`default_nettype none
module tks_assertions
  import tks_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       cfg_irq_enable,
  input wire logic       cfg_run,
  input wire logic       event_read,
  input wire logic       fault_clear,
  input wire logic       touch_irq,
  input wire logic       event_valid,
  input wire logic       event_empty,
  input wire logic [4:0] event_count,
  input wire logic [7:0] fault_vdd,
  input wire logic [7:0] fault_vss,
  input wire logic       fault_any,
  input wire logic       scanning
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Interrupt lags the pending state by one edge
  chk_irq_pending: assert property (touch_irq == $past(!event_empty && cfg_irq_enable))
    else $error("interrupt does not follow pending events");
  chk_count_max: assert property (event_count <= TKS_FIFO_DEPTH)
    else $error("store count above depth");
  chk_empty_flag: assert property (event_empty == (event_count == 5'h0))
    else $error("empty flag disagrees with count");
  chk_pop_valid: assert property (event_read && !event_empty |=> event_valid)
    else $error("pop gave no event");
  chk_no_spurious: assert property (!(event_read && !event_empty) |=> !event_valid)
    else $error("event without pop");
  chk_fault_or: assert property (fault_any == |{fault_vdd, fault_vss})
    else $error("fault summary wrong");
  chk_fault_sticky: assert property (!fault_clear |=>
    (({fault_vdd, fault_vss} & $past({fault_vdd, fault_vss})) == $past({fault_vdd, fault_vss})))
    else $error("fault flag lost without clear");
  chk_halt_scan: assert property (fault_any |=> !scanning)
    else $error("scan kept running on fault");
  chk_scan_mode: assert property (!fault_any |=> scanning == $past(cfg_run))
    else $error("scan state wrong without fault");
  cover property (event_valid);
  cover property (event_count == TKS_FIFO_DEPTH);
  cover property (fault_any ##1 !scanning);
endmodule
bind tks_sensor tks_assertions i_tks_assertions (.*);
`default_nettype wire

// file: tb/tks_host.sv
// Host model: configures, idles, drains events, clears faults.
// Assumes the core ports on the same clock; hold keeps the host idle and delays the start of a drain, not one under way.
`timescale 1ns/1ps
`default_nettype none
module tks_host (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       hold,
  input  wire logic       touch_irq,
  input  wire logic       event_empty,
  input  wire logic       event_valid,
  input  wire logic [3:0] event_data,
  input  wire logic       fault_any,
  output logic            cfg_irq_enable,
  output logic            cfg_run,
  output logic            fault_clear,
  output logic            event_read,
  output logic [3:0]      last_event
);
  logic [2:0] st;
  // One step per edge; waits on the sensor's interrupt and empty flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= 3'h0;
      cfg_irq_enable <= 1'b0;
      cfg_run <= 1'b0;
      fault_clear <= 1'b0;
      event_read <= 1'b0;
      last_event <= 4'h0;
    end else begin
      if (event_valid)
        last_event <= event_data;
      case (st)
        3'h0: begin
          cfg_irq_enable <= 1'b1;
          cfg_run <= 1'b1;
          st <= 3'h1;
        end
        3'h1: if (touch_irq && !hold) st <= 3'h2;
        // Pops spaced so empty is seen fresh
        3'h2: if (event_read) event_read <= 1'b0;
          else if (!event_empty) event_read <= 1'b1;
          else st <= 3'h3;
        3'h3: st <= fault_any ? 3'h4 : 3'h1;
        3'h4: begin
          cfg_run <= 1'b0;
          st <= 3'h5;
        end
        3'h5: begin
          fault_clear <= 1'b1;
          st <= 3'h6;
        end
        default: begin
          fault_clear <= 1'b0;
          cfg_run <= 1'b1;
          st <= 3'h1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: tb/tks_sensor_bench.sv
// Bench for the touch sensor core with the host model at its far side.
// Assumes the package, core, host model and bound checker.
`timescale 1ns/1ps
`default_nettype none
module tks_sensor_bench;
  import tks_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, hold = 1'b0;
  logic [7:0] touch_pin = 8'h0, short_vdd_pin = 8'h0, short_vss_pin = 8'h0;
  logic       cfg_irq_enable, cfg_run, fault_clear, event_read, touch_irq;
  logic       event_valid, event_empty, fault_any, scanning;
  logic [3:0] event_data, last_event, last_exp;
  logic [4:0] event_count;
  logic [7:0] fault_vdd, fault_vss;
  logic [3:0] exp_q[$];
  int         failures = 0, compares = 0, seed = 82304, k, idx, e;
  always #2 clk = ~clk;
  tks_sensor i_tks_sensor (.*);
  tks_host i_tks_host (.*);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Toggle one electrode, note the event, wait out sync and a scan
  task automatic flip(input int n);
    touch_pin[n] = ~touch_pin[n];
    last_exp = {touch_pin[n], 3'(n)};
    exp_q.push_back(last_exp);
    repeat (12) @(posedge clk);
    #1;
  endtask
  // Bounded wait until every noted event was popped
  task automatic drain;
    for (k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge clk);
    if (exp_q.size() > 0) begin
      failures++;
      print_verdict;
    end
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Oldest note against each popped event
  always @(negedge clk)
    if (event_valid === 1'b1)
      check(event_data, exp_q.size() ? 16'(exp_q.pop_front()) : 16'h1f0);
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    for (idx = 0; idx < 6; idx++) flip($random(seed) & 7);
    drain;
    check(last_event, last_exp);
    $display("test single events done");
    // Fill past depth while host waits; the extra change must be held
    hold = 1'b1;
    for (idx = 0; idx < 31; idx++) flip($random(seed) & 7);
    check(event_count, TKS_FIFO_DEPTH);
    check(touch_irq, 1'b1);
    hold = 1'b0;
    drain;
    check(event_empty, 1'b1);
    $display("test full store done");
    for (idx = 0; idx < 2; idx++) begin
      hold = 1'b1;
      flip(3);
      e = $random(seed) & 7;
      if (idx) short_vss_pin[e] = 1'b1;
      else short_vdd_pin[e] = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      check({fault_vss, fault_vdd}, 16'h1 << (e + 8 * idx));
      check(scanning, 1'b0);
      short_vdd_pin = 8'h0;
      short_vss_pin = 8'h0;
      flip(5);
      check(event_count, 5'h1);
      hold = 1'b0;
      drain;
      check({fault_any, scanning}, 2'h1);
    end
    $display("test fault clear done");
    print_verdict;
  end
endmodule
`default_nettype wire
